// File: shared/spfp_consts.svh
// Register addresses, field positions and reset values of the post divider block.
`ifndef SPFP_CONSTS_SVH
`define SPFP_CONSTS_SVH
`define SPFP_ADDR_PAGE      7'h7F
`define SPFP_ADDR_B_LO      8'h83
`define SPFP_ADDR_C_LO      8'h86
`define SPFP_REG_BYTES      3
`define SPFP_RST_B          24'h000002
`define SPFP_RST_C          24'h000040
`define SPFP_B_RATIO_MSB    22
`define SPFP_C_MODE_MSB     23
`define SPFP_C_MODE_LSB     20
`define SPFP_C_FRAME_CODE   4'hF
`define SPFP_C_TYPE_BIT     19
`define SPFP_C_POL_BIT      18
`define SPFP_C_SEL_MSB      17
`define SPFP_C_SEL_LSB      16
`define SPFP_C_PERIOD_MSB   15
`define SPFP_SEL_RSVD       2'h0
`define SPFP_SEL_A          2'h1
`define SPFP_SEL_SELF       2'h2
`define SPFP_SEL_D          2'h3
`endif

// File: shared/spfp_pkg.sv
// Types shared by the post divider block and its bench.
package spfp_pkg;
  // One access on the byte-wide control port, already de-serialised.
  typedef struct packed {
    logic [6:0] addr;   // Seven address bits; the page bit supplies the eighth.
    logic       wr_en;  // One-cycle write strobe.
    logic       rd_en;  // One-cycle read strobe.
    logic [7:0] wdata;  // Write byte.
  } spfp_req_s;

  // Output mode of divider C.
  typedef enum logic {
    SPFP_MODE_CLOCK,
    SPFP_MODE_FRAME
  } spfp_mode_e;
endpackage

// File: verif/synth_post_divider_frame_pulse_tb.sv
// Self-checking bench for the post divider B and C block with frame pulse mode.
`timescale 1ns/100ps
`default_nettype none
`include "spfp_consts.svh"
module synth_post_divider_frame_pulse_tb;
  import spfp_pkg::*;
  logic       sys_clk    = 1'b0;  // 20 MHz system clock.
  logic       arst_n     = 1'b0;  // Asynchronous reset, active low.
  spfp_req_s  reg_req    = '0;    // Byte port request.
  logic [7:0] rd_data;            // Read byte from the design.
  logic       synth_tick = 1'b1;  // A synthesizer event on every cycle unless halved.
  logic       tick_half  = 1'b0;  // Ticks on every other cycle when set.
  logic       rel_clk_a  = 1'b0;  // Related clock A, period 8 cycles.
  logic       rel_clk_d  = 1'b0;  // Related clock D, period 16 cycles.
  logic       div_b_clk;          // Divider B output.
  logic       div_c_out;          // Divider C output.
  logic [3:0] rel_cnt    = 4'h0;  // Free counter behind both related clocks.
  int         fails      = 0;     // Mismatches seen.
  int         n_tests    = 0;     // Comparisons made.
  int         cycles     = 0;     // Cycle count for the hang guard.
  // Frame settings; none selects divider C itself as its related clock.
  logic [23:0] c_tab [7] = '{24'hF10004, 24'hF90004, 24'hF50004, 24'hF30002, 24'hF00004, 24'hF10000,
                             24'hF10001};
  int          h_tab [7] = '{32, 32, 96, 64, 0, 0, 128};  // High cycles per 128.
  int          r_tab [7] = '{4, 4, 4, 4, 0, 0, 0};        // Rising edges per 128.

  always #25 sys_clk = ~sys_clk;

  spfp_top dut (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .reg_req    (reg_req),
    .rd_data    (rd_data),
    .synth_tick (synth_tick),
    .rel_clk_a  (rel_clk_a),
    .rel_clk_d  (rel_clk_d),
    .div_b_clk  (div_b_clk),
    .div_c_out  (div_c_out)
  );

  // Related clocks change at the falling edge so the design samples settled levels.
  always @(negedge sys_clk) begin
    rel_cnt   <= rel_cnt + 4'h1;
    rel_clk_a <= rel_cnt[2];
    rel_clk_d <= rel_cnt[3];
    synth_tick <= tick_half ? ~synth_tick : 1'b1;
  end

  // Hang guard: the whole run needs about 2500 cycles, so 20000 means something stuck.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      complete_run();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares one value and reports any difference.
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One write strobe; only the low seven address bits travel, the page bit adds the eighth.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req <= '{addr: a[6:0], wr_en: 1'b1, rd_en: 1'b0, wdata: d};
    @(negedge sys_clk);
    reg_req <= '0;
  endtask

  // One read strobe; the byte is taken half a cycle after the answering edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_req <= '{addr: a[6:0], wr_en: 1'b0, rd_en: 1'b1, wdata: 8'h00};
    @(negedge sys_clk);
    reg_req <= '0;
    d = rd_data;
  endtask

  // Three bytes, low byte at the base address.
  task automatic wr24(input logic [7:0] a, input logic [23:0] v);
    for (int i = 0; i < 3; i++) wr(a + 8'(i), v[8*i +: 8]);
  endtask

  task automatic rd24(input logic [7:0] a, output logic [23:0] v);
    logic [7:0] b;
    for (int i = 0; i < 3; i++) begin
      rd(a + 8'(i), b);
      v[8*i +: 8] = b;
    end
  endtask

  // Counts high samples and rising edges of one output over n cycles.
  task automatic measure(input logic sel_c, input int n, output int highs, output int rises);
    logic prev;
    logic cur;
    @(negedge sys_clk);
    prev  = sel_c ? div_c_out : div_b_clk;
    highs = 0;
    rises = 0;
    repeat (n) begin
      @(negedge sys_clk);
      cur = sel_c ? div_c_out : div_b_clk;
      if (cur === 1'b1) highs++;
      if (cur === 1'b1 && prev === 1'b0) rises++;
      prev = cur;
    end
  endtask

  // Reset values, paging, reserved page bits and an unmapped address.
  task automatic t_regs();
    logic [7:0]  b;
    logic [23:0] v;
    int          h;
    int          r;
    rd(8'h7F, b); check("page reset", 24'(b), 24'h0);
    rd(8'h03, b); check("page 0 hole", 24'(b), 24'h0);
    wr(8'h7F, 8'hFF);
    rd(8'h7F, b); check("page bits", 24'(b), 24'h01);
    rd24(`SPFP_ADDR_B_LO, v); check("b reset", v, `SPFP_RST_B);
    rd24(`SPFP_ADDR_C_LO, v); check("c reset", v, `SPFP_RST_C);
    wr(8'h90, 8'hAA);
    rd(8'h90, b); check("unmapped", 24'(b), 24'h0);
    measure(1'b0, 60, h, r);
    check("b ratio 2 high", 24'(h), 24'd30);
    check("b ratio 2 rises", 24'(r), 24'd30);
    measure(1'b1, 128, h, r);
    check("c ratio 64 high", 24'(h), 24'd64);
    check("c ratio 64 rises", 24'(r), 24'd2);
  endtask

  // Divider B with an odd ratio: shorter high phase, exact period.
  task automatic t_div_b();
    logic [23:0] v;
    int          h;
    int          r;
    wr24(`SPFP_ADDR_B_LO, 24'h000005);
    rd24(`SPFP_ADDR_B_LO, v); check("b readback", v, 24'h000005);
    repeat (10) @(negedge sys_clk);
    measure(1'b0, 60, h, r);
    check("b ratio 5 high", 24'(h), 24'd24);
    check("b ratio 5 rises", 24'(r), 24'd12);
    // Half-rate synthesizer events stretch the period to ten cycles.
    tick_half = 1'b1;
    repeat (10) @(negedge sys_clk);
    measure(1'b0, 100, h, r);
    check("b half rate high", 24'(h), 24'd40);
    check("b half rate rises", 24'(r), 24'd10);
    tick_half = 1'b0;
  endtask

  // Divider C clock mode at ratios 6, 7 and 8.
  task automatic t_div_c();
    int h;
    int r;
    for (int n = 6; n <= 8; n++) begin
      wr24(`SPFP_ADDR_C_LO, 24'(n));
      repeat (20) @(negedge sys_clk);
      measure(1'b1, n * 10, h, r);
      check("c clock high", 24'(h), 24'((n / 2) * 10));
      check("c clock rises", 24'(r), 24'd10);
    end
    // Ratio 1 runs as 2; ratio 0 parks the output low.
    wr24(`SPFP_ADDR_C_LO, 24'h000001);
    repeat (20) @(negedge sys_clk);
    measure(1'b1, 40, h, r);
    check("c ratio 1 high", 24'(h), 24'd20);
    check("c ratio 1 rises", 24'(r), 24'd20);
    wr24(`SPFP_ADDR_C_LO, 24'h000000);
    repeat (20) @(negedge sys_clk);
    measure(1'b1, 40, h, r);
    check("c ratio 0 high", 24'(h), 24'd0);
    check("c ratio 0 rises", 24'(r), 24'd0);
  endtask

  // Frame pulse mode: both types, both polarities, both related clocks, reserved code, period 1.
  task automatic t_frame();
    logic [23:0] v;
    int          h;
    int          r;
    for (int i = 0; i < 7; i++) begin
      wr24(`SPFP_ADDR_C_LO, c_tab[i]);
      rd24(`SPFP_ADDR_C_LO, v); check("c readback", v, c_tab[i]);
      repeat (96) @(negedge sys_clk);
      measure(1'b1, 128, h, r);
      check("frame high", 24'(h), 24'(h_tab[i]));
      check("frame rises", 24'(r), 24'(r_tab[i]));
    end
  endtask

  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial begin
    repeat (10) @(negedge sys_clk);
    arst_n = 1'b1;
    t_regs();
    t_div_b();
    t_div_c();
    t_frame();
    complete_run();
  end
endmodule // synth_post_divider_frame_pulse_tb
`default_nettype wire

// File: verilog/spfp_div_core.sv
// Tick-driven post divider producing a near 50% clock level.
`timescale 1ns/100ps
`default_nettype none
module spfp_div_core (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        tick,
  input  wire logic [23:0] ratio,
  output var  logic        clk_out
);
  import spfp_pkg::*;

  logic [23:0] cnt_ff;      // Position inside the current output period.
  logic [23:0] eff_ratio;   // Ratio with 1 promoted to 2.
  logic [23:0] nxt_cnt;     // Count after this tick.
  logic [23:0] high_len;    // Ticks spent high per period.

  // A ratio of 1 cannot be built from whole ticks, so it runs as 2.
  assign eff_ratio = (ratio == 24'h000001) ? 24'h000002 : ratio;
  assign nxt_cnt   = (cnt_ff >= eff_ratio - 24'h000001) ? 24'h000000 : cnt_ff + 24'h000001;
  // Odd ratios spend the shorter half high, so duty drops below 50% at small odd ratios.
  assign high_len  = eff_ratio >> 1;

  // Count ticks and derive the level; a zero ratio parks the output low.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff  <= 24'h000000;
      clk_out <= 1'b0;
    end else if (ratio == 24'h000000) begin
      cnt_ff  <= 24'h000000;
      clk_out <= 1'b0;
    end else if (tick) begin
      cnt_ff  <= nxt_cnt;                   // [RULE1] [RULE4]
      clk_out <= (nxt_cnt < high_len);      // [RULE5]
    end
  end

  // Helper: ticks since the last rising edge of the output.
  // It is cleared together with the count so a parked divider restarts in step with it.
  logic [23:0] hi_run_ff;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_run_ff <= 24'h000000;
    end else if (ratio == 24'h000000) begin
      hi_run_ff <= 24'h000000;
    end else if (tick) begin
      hi_run_ff <= (nxt_cnt == 24'h000000) ? 24'h000000 : hi_run_ff + 24'h000001;
    end
  end

  // The level was decided with the ratio of the cycle before, which a write may just have replaced.
  a_core_duty: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE5]
    (tick && ratio > 24'h000001 && $stable(ratio)) |=> (clk_out == (hi_run_ff < ($past(ratio) >> 1))))
    else $error("Divider level does not match its position in the period.");

  a_core_zero: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE4]
    (ratio == 24'h000000) |=> !clk_out)
    else $error("Divider output not parked low at zero ratio.");
endmodule // spfp_div_core
`default_nettype wire

// File: verilog/spfp_top.sv
// Post dividers B and C with frame pulse generation behind the paged byte port.
`timescale 1ns/100ps
`default_nettype none
`include "spfp_consts.svh"

// How it works
// RULE1: Divider B divides synthesizer by bits 22:0.
// RULE2: Software keeps divider B bit 23 at zero.
// RULE3: Top nibble all ones gives repeating frame pulse.
// RULE4: Otherwise C outputs 50% clock, full ratio.
// RULE5: Odd small ratios may skew duty cycle.
// RULE6: Software prefers ratio 8 over ratio 7.
// RULE7: Bits 17:16 pick related clock, width one period.
// RULE8: Software never selects C as its own clock.
// RULE9: Bit 18 polarity, bit 19 boundary placement.
// RULE10: Software sets page bit before upper addresses.
// RULE11: Three bytes per register, low byte first.
module spfp_top (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire spfp_pkg::spfp_req_s reg_req,
  output var  logic [7:0]        rd_data,
  input  wire logic              synth_tick,
  input  wire logic              rel_clk_a,
  input  wire logic              rel_clk_d,
  output var  logic              div_b_clk,
  output var  logic              div_c_out
);
  import spfp_pkg::*;

  logic        page_ff;        // Page select bit.
  logic [23:0] reg_b_ff;       // Divider B ratio register.
  logic [23:0] reg_c_ff;       // Divider C ratio or frame register.
  logic [7:0]  full_addr;      // Address with the page bit prepended.
  logic [7:0]  rd_mux;         // Read byte selected by the address.
  logic        page_hit;       // Access to the page register.
  logic [2:0]  b_hit;          // Per byte hits of register B.
  logic [2:0]  c_hit;          // Per byte hits of register C.

  // The page register answers at 0x7F on both pages; everything else uses the page bit.
  assign full_addr = {page_ff, reg_req.addr};
  assign page_hit  = (reg_req.addr == `SPFP_ADDR_PAGE);

  // One byte lane per generate pass: byte i of each register sits at base plus i.
  genvar gi;
  generate
    for (gi = 0; gi < `SPFP_REG_BYTES; gi++) begin : g_byte
      assign b_hit[gi] = !page_hit && (full_addr == `SPFP_ADDR_B_LO + 8'(gi));  // [RULE11]
      assign c_hit[gi] = !page_hit && (full_addr == `SPFP_ADDR_C_LO + 8'(gi));  // [RULE11]

      // Byte writes; bit 23 of B is stored but never used by the divider.
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          reg_b_ff[gi*8 +: 8] <= 8'(`SPFP_RST_B >> (gi*8));
          reg_c_ff[gi*8 +: 8] <= 8'(`SPFP_RST_C >> (gi*8));
        end else if (reg_req.wr_en) begin
          if (b_hit[gi]) begin
            reg_b_ff[gi*8 +: 8] <= reg_req.wdata;
          end
          if (c_hit[gi]) begin
            reg_c_ff[gi*8 +: 8] <= reg_req.wdata;
          end
        end
      end
    end
  endgenerate

  // Page bit write; only bit 0 is kept, the rest read as zero.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      page_ff <= 1'b0;
    end else if (reg_req.wr_en && page_hit) begin
      page_ff <= reg_req.wdata[0];
    end
  end

  // Read decode; unmapped addresses read as zero.
  assign rd_mux = page_hit    ? {7'h00, page_ff} :
                  b_hit[0]    ? reg_b_ff[7:0]    :
                  b_hit[1]    ? reg_b_ff[15:8]   :
                  b_hit[2]    ? reg_b_ff[23:16]  :
                  c_hit[0]    ? reg_c_ff[7:0]    :
                  c_hit[1]    ? reg_c_ff[15:8]   :
                  c_hit[2]    ? reg_c_ff[23:16]  : 8'h00;

  // Read data is captured on the strobe and held until the next read.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 8'h00;
    end else if (reg_req.rd_en) begin
      rd_data <= rd_mux;
    end
  end

  // Divider B uses only the low 23 bits; bit 23 is the software's to keep clear.
  logic [23:0] ratio_b;        // Effective ratio of divider B.
  assign ratio_b = {1'b0, reg_b_ff[`SPFP_B_RATIO_MSB:0]};  // [RULE1] [RULE2]

  spfp_div_core u_div_b (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .tick    (synth_tick),
    .ratio   (ratio_b),
    .clk_out (div_b_clk)
  );

  // Divider C mode and frame fields.
  spfp_mode_e  c_mode;         // Clock or frame pulse.
  logic [1:0]  c_sel;          // Related clock code.
  logic [15:0] c_period;       // Related periods between pulses.
  logic        c_pol;          // Inverted polarity when set.
  logic        c_type;         // Boundary at pulse edge when set.
  logic [23:0] ratio_c;        // Ratio handed to the clock divider.
  logic        core_c;         // Clock-mode level of divider C.

  assign c_mode   = (reg_c_ff[`SPFP_C_MODE_MSB:`SPFP_C_MODE_LSB] == `SPFP_C_FRAME_CODE) ?
                    SPFP_MODE_FRAME : SPFP_MODE_CLOCK;                    // [RULE3]
  assign c_sel    = reg_c_ff[`SPFP_C_SEL_MSB:`SPFP_C_SEL_LSB];
  assign c_period = reg_c_ff[`SPFP_C_PERIOD_MSB:0];
  assign c_pol    = reg_c_ff[`SPFP_C_POL_BIT];
  assign c_type   = reg_c_ff[`SPFP_C_TYPE_BIT];
  // In frame mode the clock divider is parked so it burns no toggles.
  assign ratio_c  = (c_mode == SPFP_MODE_CLOCK) ? reg_c_ff : 24'h000000;  // [RULE4]

  spfp_div_core u_div_c (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .tick    (synth_tick),
    .ratio   (ratio_c),
    .clk_out (core_c)
  );

  // Related clock selection; reserved and self codes give no clock and clear the pulse logic.
  logic sel_ok;                // Code names a real related clock.
  logic rel_lvl;               // Selected related clock level.
  logic rel_prev_ff;           // Its value one cycle ago.
  logic rel_rise;              // Start of a related period.
  logic rel_fall;              // Middle of a related period.
  logic fp_last;               // Current related period ends at the frame boundary.
  logic [15:0] fcnt_ff;        // Related periods since the boundary.
  logic fp_ff;                 // Frame pulse, active high before polarity.

  assign rel_lvl  = (c_sel == `SPFP_SEL_A) ? rel_clk_a :
                    (c_sel == `SPFP_SEL_D) ? rel_clk_d : 1'b0;            // [RULE7] [RULE8]
  assign sel_ok   = (c_sel == `SPFP_SEL_A) || (c_sel == `SPFP_SEL_D);            // [RULE7]
  assign rel_rise = rel_lvl && !rel_prev_ff;
  assign rel_fall = !rel_lvl && rel_prev_ff;
  assign fp_last  = (fcnt_ff == c_period - 16'h0001);

  // Count related periods and place the pulse around the boundary.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rel_prev_ff <= 1'b0;
      fcnt_ff     <= 16'h0000;
      fp_ff       <= 1'b0;
    end else if (c_mode != SPFP_MODE_FRAME || c_period == 16'h0000 || !sel_ok) begin
      // A pulse left high by an earlier valid code would otherwise freeze on.
      rel_prev_ff <= rel_lvl;
      fcnt_ff     <= 16'h0000;
      fp_ff       <= 1'b0;
    end else begin
      rel_prev_ff <= rel_lvl;
      if (rel_rise) begin
        fcnt_ff <= fp_last ? 16'h0000 : fcnt_ff + 16'h0001;             // [RULE3]
      end
      // Edge type: pulse spans the first related period after the boundary.
      if (c_type && rel_rise) begin
        fp_ff <= fp_last;                                                // [RULE7] [RULE9]
      end
      // Centred type: pulse runs from the middle of the last period to the middle of the first.
      if (!c_type && rel_fall) begin
        fp_ff <= fp_last;                                                // [RULE9]
      end
    end
  end

  // Output select and polarity, registered so the pin comes from a flop.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_c_out <= 1'b0;
    end else if (c_mode == SPFP_MODE_FRAME) begin
      div_c_out <= fp_ff ^ c_pol;                                        // [RULE9]
    end else begin
      div_c_out <= core_c;                                               // [RULE4]
    end
  end

  // Assertions on register layout, clock mode output and frame behaviour.
  sequence s_wr_b_lo;
    reg_req.wr_en && b_hit[0];
  endsequence

  sequence s_wr_c_hi;
    reg_req.wr_en && c_hit[2];
  endsequence

  a_b_low_byte: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE11]
    s_wr_b_lo |=> (reg_b_ff[7:0] == $past(reg_req.wdata)))
    else $error("Divider B low byte not written at its base address.");

  a_c_high_byte: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE11]
    s_wr_c_hi |=> (reg_c_ff[23:16] == $past(reg_req.wdata)))
    else $error("Divider C high byte not written at base plus two.");

  a_b_bit_ignored: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE1]
    (ratio_b[23] == 1'b0) && (ratio_b[22:0] == reg_b_ff[22:0]))
    else $error("Divider B ratio does not follow bits 22 to 0.");

  a_clock_mode_out: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE4]
    (c_mode == SPFP_MODE_CLOCK) [*2] |=> (div_c_out == $past(core_c)))
    else $error("Clock mode output does not follow divider C.");

  a_frame_idle_pol: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE9]
    (c_mode == SPFP_MODE_FRAME && !fp_ff) |=> (div_c_out == $past(c_pol)))
    else $error("Idle frame output has wrong polarity.");

  a_no_pulse_rsvd: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE7]
    (c_sel == `SPFP_SEL_RSVD || c_sel == `SPFP_SEL_SELF) [*2] |=> !fp_ff)
    else $error("Frame pulse formed without a valid related clock.");

  a_edge_pulse_start: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE3]
    (c_mode == SPFP_MODE_FRAME && c_period != 16'h0000 && c_type && rel_rise && fp_last)
      |=> (fp_ff && fcnt_ff == 16'h0000))
    else $error("Edge type pulse did not start at the frame boundary.");
endmodule // spfp_top
`default_nettype wire
